/* hw/debug_state_sequencer.sv */
module debug_state_sequencer
  import seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [9:0]  address,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [3:0]  match,
  input  wire logic        external_event,
  output logic [2:0]       current_state_flags,
  output logic             armed
);

  bus_req_t   req;
  bus_rsp_t   rsp_r, rsp_nxt;
  logic [7:0] scr1_r, scr1_nxt;
  logic [7:0] scr2_r, scr2_nxt;
  logic [3:0] cmp_en_r, cmp_en_nxt;
  logic       arm_r, arm_nxt;
  logic       trace_active_flag_r, trace_nxt;
  logic [1:0] evsel_r, evsel_nxt;
  seq_state_t state_r, state_nxt;
  logic       locked;
  logic [3:0] hit;

  assign req = '{read: read, write: write, address: address, writedata: writedata};

  // Highest-numbered hit picks its code; returns NS_NONE when nothing hit
  function automatic logic [1:0] pick_code(input logic [3:0] h, input logic [7:0] f);
    logic [1:0] c;
    c = NS_NONE;
    for (int i = 0; i < 4; i++) begin
      if (h[i]) begin
        c = f[2*i +: 2];
      end
    end
    return c;
  endfunction

  function automatic seq_state_t code_to_state(input logic [1:0] c, input seq_state_t s);
    seq_state_t n;
    case (c)
      NS_STATE2: n = ST_STATE2;
      NS_STATE3: n = ST_STATE3;
      NS_FINAL:  n = ST_FINAL;
      default:   n = s;
    endcase
    return n;
  endfunction

  assign locked = arm_r || trace_active_flag_r;

  always_comb begin
    hit = match & cmp_en_r;
    if (evsel_r == EVSEL_EXT) begin
      hit[3] = external_event && cmp_en_r[3];
    end
  end

  // Bus slave: one wait cycle, answer on the second edge of a request
  always_comb begin
    scr1_nxt   = scr1_r;
    scr2_nxt   = scr2_r;
    cmp_en_nxt = cmp_en_r;
    arm_nxt    = arm_r;
    trace_nxt  = trace_active_flag_r;
    evsel_nxt  = evsel_r;
    rsp_nxt    = '{readdata: rsp_r.readdata, waitrequest: 1'b1};
    if ((req.read || req.write) && rsp_r.waitrequest) begin
      rsp_nxt.waitrequest = 1'b0;
      rsp_nxt.readdata    = UNMAPPED_DATA;
      if (req.address == SCR1_ADDR) begin
        rsp_nxt.readdata = {24'h00_0000, scr1_r};
      end else if (req.address == SCR2_ADDR) begin
        rsp_nxt.readdata = {24'h00_0000, scr2_r};
      end else if (req.address == CMPCTL_ADDR) begin
        rsp_nxt.readdata = {28'h000_0000, cmp_en_r};
      end else if (req.address == CTRL_ADDR) begin
        rsp_nxt.readdata = {26'h000_0000, evsel_r, 2'b00, trace_active_flag_r, arm_r};
      end else if (req.address == STATUS_ADDR) begin
        rsp_nxt.readdata = {29'h0000_0000, state_r};
      end
    end
    // Writes land only on the edge at which the master sees waitrequest low
    if (req.write && !rsp_r.waitrequest) begin
      if (req.address == SCR1_ADDR) begin
        if (!locked) begin
          scr1_nxt = req.writedata[7:0];
        end
      end else if (req.address == SCR2_ADDR) begin
        if (!locked) begin
          scr2_nxt = req.writedata[7:0];
        end
      end else if (req.address == CMPCTL_ADDR) begin
        if (!locked) begin
          cmp_en_nxt = req.writedata[3:0];
        end
      end else if (req.address == CTRL_ADDR) begin
        arm_nxt   = req.writedata[CTRL_ARM_BIT];
        trace_nxt = req.writedata[CTRL_TRACE_BIT];
        evsel_nxt = req.writedata[CTRL_EVSEL_LSB +: 2];
      end
    end
  end

  // Sequencer: arming enters State1, disarming returns to idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (arm_r) begin
          state_nxt = ST_STATE1;
        end
      end
      ST_STATE1: begin
        state_nxt = code_to_state(pick_code(hit, scr1_r), state_r);
      end
      ST_STATE2: begin
        state_nxt = code_to_state(pick_code({2'b00, hit[1:0]}, {4'h0, scr2_r[3:0]}), state_r);
      end
      default: begin
        state_nxt = state_r;
      end
    endcase
    if (!arm_r) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scr1_r              <= SCR1_RESET;
      scr2_r              <= SCR2_RESET;
      cmp_en_r            <= CMPEN_RESET;
      arm_r               <= 1'b0;
      trace_active_flag_r <= 1'b0;
      evsel_r             <= EVSEL_RESET;
      rsp_r               <= '{readdata: UNMAPPED_DATA, waitrequest: 1'b1};
      state_r             <= ST_IDLE;
      current_state_flags <= 3'b000;
      armed               <= 1'b0;
    end else begin
      scr1_r              <= scr1_nxt;
      scr2_r              <= scr2_nxt;
      cmp_en_r            <= cmp_en_nxt;
      arm_r               <= arm_nxt;
      trace_active_flag_r <= trace_nxt;
      evsel_r             <= evsel_nxt;
      rsp_r               <= rsp_nxt;
      state_r             <= state_nxt;
      current_state_flags <= state_nxt;
      armed               <= arm_nxt;
    end
  end

  always_comb begin
    readdata    = rsp_r.readdata;
    waitrequest = rsp_r.waitrequest;
  end

  chk_locked_write_hold: assert property (@(posedge clk) disable iff (reset)
    (write && address == SCR1_ADDR && locked) |=> (scr1_r == $past(scr1_r)))
    else $error("state1 control changed while locked");

  chk_scr2_write_takes: assert property (@(posedge clk) disable iff (reset)
    (write && address == SCR2_ADDR && !locked && !waitrequest)
    |=> (scr2_r == $past(writedata[7:0])))
    else $error("state2 control write not stored");

  chk_state1_final: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE1 && arm_r && hit[0] && hit[3:1] == 3'b000 && scr1_r[1:0] == NS_FINAL)
    |=> state_r == ST_FINAL)
    else $error("channel 0 final transition missed");

  chk_priority_high: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE1 && arm_r && hit[3] && scr1_r[7:6] == NS_STATE3)
    |=> state_r == ST_STATE3)
    else $error("channel 3 did not win priority");

  chk_ext_event: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE1 && arm_r && evsel_r == EVSEL_EXT && cmp_en_r[3] && external_event
     && scr1_r[7:6] == NS_STATE2) |=> state_r == ST_STATE2)
    else $error("external event ignored");

  chk_code_none: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE1 && arm_r && hit == 4'h1 && scr1_r[1:0] == NS_NONE)
    |=> state_r == ST_STATE1)
    else $error("code 00 moved the sequencer");

  chk_state2_table: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE2 && arm_r && hit[1] && scr2_r[3:2] == NS_FINAL)
    |=> state_r == ST_FINAL)
    else $error("state2 channel 1 transition missed");

  chk_disabled_chan: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE1 && arm_r && cmp_en_r == 4'h0) |=> state_r == ST_STATE1)
    else $error("disabled comparator moved the sequencer");

  chk_enable_bit: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STATE2 && arm_r && match[0] && cmp_en_r[0] && match[1] == 1'b0
     && scr2_r[1:0] == NS_STATE3) |=> state_r == ST_STATE3)
    else $error("enabled comparator 0 ignored");

  sequence bus_req_start;
    (read || write) && waitrequest;
  endsequence

  sequence bus_req_done;
    (read || write) && !waitrequest;
  endsequence

  sequence scr1_write_done;
    write && address == SCR1_ADDR && !waitrequest && !locked;
  endsequence

  chk_bus_wait_one: assert property (@(posedge clk) disable iff (reset)
    bus_req_start |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  chk_bus_wait_release: assert property (@(posedge clk) disable iff (reset)
    bus_req_done |=> waitrequest)
    else $error("waitrequest stayed low past the answer");

  chk_scr1_write_takes: assert property (@(posedge clk) disable iff (reset)
    scr1_write_done |=> (scr1_r == $past(writedata[7:0])))
    else $error("state1 control write not stored");

endmodule

/* hw/seq_pkg.sv */
package seq_pkg;

  // Register word addresses (byte addresses on the Avalon-MM slave)
  localparam logic [9:0] SCR1_ADDR    = 10'h104;
  localparam logic [9:0] SCR2_ADDR    = 10'h108;
  localparam logic [9:0] CMPCTL_ADDR  = 10'h10C;
  localparam logic [9:0] CTRL_ADDR    = 10'h100;
  localparam logic [9:0] STATUS_ADDR  = 10'h120;

  // Field positions
  localparam int CMP_EN_BIT       = 0;
  localparam int CTRL_ARM_BIT     = 0;
  localparam int CTRL_TRACE_BIT   = 1;
  localparam int CTRL_EVSEL_LSB   = 4;

  // Reset values, and the event select code for the external event
  localparam logic [7:0] SCR1_RESET   = 8'h00;
  localparam logic [7:0] SCR2_RESET   = 8'h00;
  localparam logic [3:0] CMPEN_RESET  = 4'h0;
  localparam logic [1:0] EVSEL_RESET  = 2'b00;
  localparam logic [1:0] EVSEL_EXT    = 2'b10;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // Next-state codes
  localparam logic [1:0] NS_NONE   = 2'b00;
  localparam logic [1:0] NS_STATE2 = 2'b01;
  localparam logic [1:0] NS_STATE3 = 2'b10;
  localparam logic [1:0] NS_FINAL  = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_STATE1 = 3'b001,
    ST_STATE2 = 3'b010,
    ST_STATE3 = 3'b011,
    ST_FINAL  = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } bus_rsp_t;

endpackage

/* verif/match_source.sv */
module match_source (
  input  wire logic clk,
  output logic [3:0] match,
  output logic       external_event
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    match = 4'h0;
    external_event = 1'b0;
  end

  // Raw hits for one cycle; enable gating is left to the sequencer
  task automatic hit(input logic [3:0] m, input logic x);
    @(posedge clk);
    match <= m;
    external_event <= x;
    @(posedge clk);
    match <= 4'h0;
    external_event <= 1'b0;
  endtask
endmodule

/* verif/tb_top.sv */
module tb_top;
  import seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [3:0] en;
    logic [1:0] ev;
    logic [3:0] m1;
    logic [3:0] m2;
    logic       x;
    logic [2:0] st;
  } row_t;

  logic        clk;
  logic        reset;
  logic        read;
  logic        write;
  logic [9:0]  address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  match;
  logic        external_event;
  logic [2:0]  current_state_flags;
  logic        armed;
  logic [31:0] d;
  int          fail_count;
  int          cmp_count;
  row_t        rows [17] = '{
    '{8'h01, 8'h00, 4'hf, 2'h0, 4'h1, 4'h0, 1'b0, 3'h2},
    '{8'h08, 8'h00, 4'hf, 2'h0, 4'h2, 4'h0, 1'b0, 3'h3},
    '{8'h30, 8'h00, 4'hf, 2'h0, 4'h4, 4'h0, 1'b0, 3'h4},
    '{8'h40, 8'h00, 4'hf, 2'h0, 4'h8, 4'h0, 1'b0, 3'h2},
    '{8'hE4, 8'h00, 4'hf, 2'h0, 4'h7, 4'h0, 1'b0, 3'h3},
    '{8'hE4, 8'h00, 4'hf, 2'h0, 4'hf, 4'h0, 1'b0, 3'h4},
    '{8'h00, 8'h00, 4'hf, 2'h0, 4'h1, 4'h0, 1'b0, 3'h1},
    '{8'h03, 8'h00, 4'he, 2'h0, 4'h1, 4'h0, 1'b0, 3'h1},
    '{8'hC0, 8'h00, 4'hf, 2'h2, 4'h8, 4'h0, 1'b0, 3'h1},
    '{8'hC0, 8'h00, 4'hf, 2'h2, 4'h0, 4'h0, 1'b1, 3'h4},
    '{8'hC0, 8'h00, 4'hf, 2'h0, 4'h0, 4'h0, 1'b1, 3'h1},
    '{8'h03, 8'h00, 4'hf, 2'h0, 4'h1, 4'h0, 1'b0, 3'h4},
    '{8'h8F, 8'h00, 4'hf, 2'h0, 4'hf, 4'h0, 1'b0, 3'h3},
    '{8'h40, 8'h00, 4'hf, 2'h2, 4'h0, 4'h0, 1'b1, 3'h2},
    '{8'hFF, 8'h00, 4'h0, 2'h0, 4'hf, 4'h0, 1'b0, 3'h1},
    '{8'h01, 8'h0E, 4'hf, 2'h0, 4'h1, 4'h1, 1'b0, 3'h3},
    '{8'h01, 8'h0E, 4'hf, 2'h1, 4'h1, 4'h3, 1'b0, 3'h4}
  };

  debug_state_sequencer debug_state_sequencer_i (
    .clk                 (clk),
    .reset               (reset),
    .read                (read),
    .write               (write),
    .address             (address),
    .writedata           (writedata),
    .readdata            (readdata),
    .waitrequest         (waitrequest),
    .match               (match),
    .external_event      (external_event),
    .current_state_flags (current_state_flags),
    .armed               (armed)
  );

  match_source match_source_i (
    .clk            (clk),
    .match          (match),
    .external_event (external_event)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic xfer(input logic rw, input logic [9:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
    @(posedge clk);
    read <= ~rw;
    write <= rw;
    address <= a;
    writedata <= wd;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic run(input row_t r);
    xfer(1'b1, CTRL_ADDR, {26'h0, r.ev, 4'h0}, d);
    xfer(1'b1, SCR1_ADDR, {24'h0, r.s1}, d);
    xfer(1'b1, SCR2_ADDR, {24'h0, r.s2}, d);
    xfer(1'b1, CMPCTL_ADDR, {28'h0, r.en}, d);
    xfer(1'b1, CTRL_ADDR, {26'h0, r.ev, 4'h1}, d);
    repeat (2) @(posedge clk);
    chk(32'(current_state_flags), 32'(ST_STATE1));
    match_source_i.hit(r.m1, r.x);
    if (r.m2 !== 4'h0) match_source_i.hit(r.m2, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(current_state_flags), 32'(r.st));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    fail_count = 0;
    cmp_count = 0;
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) run(rows[i]);
    xfer(1'b1, SCR2_ADDR, 32'h0000_00FF, d);
    xfer(1'b0, SCR2_ADDR, 32'h0000_0000, d);
    chk(d, 32'h0000_000E);
    xfer(1'b1, CTRL_ADDR, 32'h0000_0002, d);
    xfer(1'b1, SCR1_ADDR, 32'h0000_00FF, d);
    xfer(1'b0, SCR1_ADDR, 32'h0000_0000, d);
    chk(d, 32'h0000_0001);
    xfer(1'b1, CTRL_ADDR, 32'h0000_0000, d);
    xfer(1'b1, SCR1_ADDR, 32'h0000_005A, d);
    xfer(1'b0, SCR1_ADDR, 32'h0000_0000, d);
    chk(d, 32'h0000_005A);
    xfer(1'b0, 10'h1F0, 32'h0000_0000, d);
    chk(d, UNMAPPED_DATA);
    xfer(1'b0, CMPCTL_ADDR, 32'h0000_0000, d);
    chk(d, 32'h0000_000F);
    xfer(1'b1, CTRL_ADDR, 32'h0000_0001, d);
    xfer(1'b0, STATUS_ADDR, 32'h0000_0000, d);
    chk(d, 32'(ST_STATE1));
    chk(32'(armed), 32'h0000_0001);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    xfer(1'b0, SCR1_ADDR, 32'h0000_0000, d);
    chk(d, {24'h0, SCR1_RESET});
    xfer(1'b0, SCR2_ADDR, 32'h0000_0000, d);
    chk(d, {24'h0, SCR2_RESET});
    chk(32'(current_state_flags), 32'(ST_IDLE));
    chk(32'(armed), 32'h0000_0000);
    results();
  end
endmodule
